// File: verilog/l1_cache_defines.vh
`ifndef L1_CACHE_DEFINES_VH
`define L1_CACHE_DEFINES_VH

// ----------------------------------------
// core control register layout
// ----------------------------------------
`define CTL_WIDTH        2
`define CTL_IC_BIT       0
`define CTL_DC_BIT       1
`define CTL_RESET        2'h0

// ----------------------------------------
// cache geometry
// ----------------------------------------
`define LINE_COUNT       16
`define INDEX_WIDTH      4
`define ADDR_WIDTH       32
`define DATA_WIDTH       32
`define TAG_WIDTH        28
`define TAG_LSB          4

// ----------------------------------------
// port selects
// ----------------------------------------
`define PORT_D           1'h0
`define PORT_I           1'h1

`endif

// File: verilog/line_store.v
`timescale 1ns/1ps
`include "l1_cache_defines.vh"

// one cache array: valid bits, tags and data, registered read
module line_store (
    // clock and reset
    input  wire                        clock,
    input  wire                        rst_n,
    // lookup
    input  wire [`INDEX_WIDTH-1:0]     rdIndex,
    output reg                         rdValid_q,
    output reg  [`TAG_WIDTH-1:0]       rdTag_q,
    output reg  [`DATA_WIDTH-1:0]      rdData_q,
    // update
    input  wire                        wrEn,
    input  wire [`INDEX_WIDTH-1:0]     wrIndex,
    input  wire [`TAG_WIDTH-1:0]       wrTag,
    input  wire [`DATA_WIDTH-1:0]      wrData,
    // invalidate
    input  wire                        invEn,
    input  wire [`INDEX_WIDTH-1:0]     invIndex,
    input  wire                        invAll
);
    reg [`LINE_COUNT-1:0] valid_q;
    reg [`TAG_WIDTH-1:0]  tagMem [0:`LINE_COUNT-1];
    reg [`DATA_WIDTH-1:0] dataMem [0:`LINE_COUNT-1];

    // ----------------------------------------
    // valid bits, one flop each
    // ----------------------------------------
    genvar g;
    generate
        for (g = 0; g < `LINE_COUNT; g = g + 1) begin : gValid
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    valid_q[g] <= 1'b0;
                // clear beats fill: a snoop racing a fill must not leave a stale line valid
                end else if (invAll || (invEn && invIndex == g)) begin
                    valid_q[g] <= 1'b0;
                end else if (wrEn && wrIndex == g) begin
                    valid_q[g] <= 1'b1;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // arrays, no reset
    // ----------------------------------------
    always @(posedge clock) begin
        if (wrEn) begin
            tagMem[wrIndex]  <= wrTag;
            dataMem[wrIndex] <= wrData;
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rdValid_q <= 1'b0;
            rdTag_q   <= {`TAG_WIDTH{1'b0}};
            rdData_q  <= {`DATA_WIDTH{1'b0}};
        end else begin
            rdValid_q <= valid_q[rdIndex];
            rdTag_q   <= tagMem[rdIndex];
            rdData_q  <= dataMem[rdIndex];
        end
    end

endmodule

// File: verilog/l1_cache_enable_control.v
`timescale 1ns/1ps
`include "l1_cache_defines.vh"

module l1_cache_enable_control #(
    parameter DC_BUILT = 1,
    parameter IC_BUILT = 1
) (
    // clock and reset
    input  wire                        clock,
    input  wire                        rst_n,
    // control register access
    input  wire                        ctlWrite,
    input  wire [`CTL_WIDTH-1:0]       ctlWrData,
    output wire [`CTL_WIDTH-1:0]       ctlRdData,
    // data side request from core
    input  wire                        dReq,
    input  wire                        dWrite,
    input  wire                        dIo,
    input  wire [`ADDR_WIDTH-1:0]      dAddr,
    input  wire [`DATA_WIDTH-1:0]      dWrData,
    output wire                        dReady,
    output reg                         dDone_q,
    output reg  [`DATA_WIDTH-1:0]      dRdData_q,
    // instruction side request from core
    input  wire                        iReq,
    input  wire [`ADDR_WIDTH-1:0]      iAddr,
    output wire                        iReady,
    output reg                         iDone_q,
    output reg  [`DATA_WIDTH-1:0]      iRdData_q,
    // software cache maintenance
    input  wire                        dFlushLine,
    input  wire                        iInvalidateAll,
    input  wire [`INDEX_WIDTH-1:0]     maintIndex,
    // coherency snoop from other agents
    input  wire                        snoopValid,
    input  wire [`ADDR_WIDTH-1:0]      snoopAddr,
    // lower cache level
    output reg                         lowReq_q,
    output reg                         lowWrite_q,
    output reg  [`ADDR_WIDTH-1:0]      lowAddr_q,
    output reg  [`DATA_WIDTH-1:0]      lowWrData_q,
    input  wire                        lowAck,
    input  wire [`DATA_WIDTH-1:0]      lowRdData
);
    localparam IDLE   = 2'h0;
    localparam LOOKUP = 2'h1;
    localparam LOWER  = 2'h2;

    // ----------------------------------------
    // control register
    // ----------------------------------------
    reg  [`CTL_WIDTH-1:0] ctl_q;
    wire [`CTL_WIDTH-1:0] builtMask;
    assign builtMask[`CTL_DC_BIT] = (DC_BUILT != 0);
    assign builtMask[`CTL_IC_BIT] = (IC_BUILT != 0);

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ctl_q <= `CTL_RESET;
        end else if (ctlWrite) begin
            ctl_q <= ctlWrData & builtMask;
        end
    end
    assign ctlRdData = ctl_q & builtMask;

    wire dcOn = ctl_q[`CTL_DC_BIT];
    wire icOn = ctl_q[`CTL_IC_BIT];

    // ----------------------------------------
    // shared sequencer, one request at a time
    // ----------------------------------------
    reg  [1:0]               state_q;
    reg                      port_q;
    reg                      write_q;
    reg                      useCache_q;
    reg  [`ADDR_WIDTH-1:0]   addr_q;
    reg  [`DATA_WIDTH-1:0]   wdata_q;

    wire idle = (state_q == IDLE);
    // data wins when both ask; fetches wait until the data access is done
    assign dReady = idle;
    assign iReady = idle && !dReq;
    wire takeD = idle && dReq;
    wire takeI = idle && !dReq && iReq;

    wire [`INDEX_WIDTH-1:0] lookIndex = addr_q[`TAG_LSB +: `INDEX_WIDTH];
    wire [`TAG_WIDTH-1:0]   lookTag   = addr_q[`ADDR_WIDTH-1:`TAG_LSB];
    // arrays read at take time, so their registered answer is ready in lookup
    wire [`INDEX_WIDTH-1:0] readIndex = takeD ? dAddr[`TAG_LSB +: `INDEX_WIDTH] :
                                        takeI ? iAddr[`TAG_LSB +: `INDEX_WIDTH] : lookIndex;

    wire                    dValid;
    wire [`TAG_WIDTH-1:0]   dTag;
    wire [`DATA_WIDTH-1:0]  dData;
    wire                    iValid;
    wire [`TAG_WIDTH-1:0]   iTag;
    wire [`DATA_WIDTH-1:0]  iData;

    wire dHit = dValid && (dTag == lookTag);
    wire iHit = iValid && (iTag == lookTag);
    wire hit  = (port_q == `PORT_D) ? dHit : iHit;

    // ----------------------------------------
    // array update: fills and store hits only while enabled; invalidates happen regardless
    // ----------------------------------------
    wire fill    = (state_q == LOWER) && lowAck && useCache_q;
    wire wHit    = (state_q == LOOKUP) && write_q && dHit;
    wire dWrEn   = (port_q == `PORT_D) && (fill || wHit) && dcOn;
    wire iWrEn   = (port_q == `PORT_I) && fill && icOn;
    wire [`DATA_WIDTH-1:0] fillData = write_q ? wdata_q : lowRdData;

    // a remote store drops the line at the snooped index, whatever its tag, so data stays coherent
    wire [`INDEX_WIDTH-1:0] snoopIndex = snoopAddr[`TAG_LSB +: `INDEX_WIDTH];
    wire dInv = dFlushLine || snoopValid;
    wire [`INDEX_WIDTH-1:0] dInvIndex = snoopValid ? snoopIndex : maintIndex;

    line_store dStore (
        .clock     (clock),
        .rst_n     (rst_n),
        .rdIndex   (readIndex),
        .rdValid_q (dValid),
        .rdTag_q   (dTag),
        .rdData_q  (dData),
        .wrEn      (dWrEn),
        .wrIndex   (lookIndex),
        .wrTag     (lookTag),
        .wrData    (fillData),
        .invEn     (dInv),
        .invIndex  (dInvIndex),
        .invAll    (1'b0)
    );

    // fetches get no snoop: software keeps them consistent
    line_store iStore (
        .clock     (clock),
        .rst_n     (rst_n),
        .rdIndex   (readIndex),
        .rdValid_q (iValid),
        .rdTag_q   (iTag),
        .rdData_q  (iData),
        .wrEn      (iWrEn),
        .wrIndex   (lookIndex),
        .wrTag     (lookTag),
        .wrData    (lowRdData),
        .invEn     (1'b0),
        .invIndex  (maintIndex),
        .invAll    (iInvalidateAll)
    );

    // ----------------------------------------
    // request sequencer
    // ----------------------------------------
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_q     <= IDLE;
            port_q      <= `PORT_D;
            write_q     <= 1'b0;
            useCache_q  <= 1'b0;
            addr_q      <= {`ADDR_WIDTH{1'b0}};
            wdata_q     <= {`DATA_WIDTH{1'b0}};
            lowReq_q    <= 1'b0;
            lowWrite_q  <= 1'b0;
            lowAddr_q   <= {`ADDR_WIDTH{1'b0}};
            lowWrData_q <= {`DATA_WIDTH{1'b0}};
            dDone_q     <= 1'b0;
            dRdData_q   <= {`DATA_WIDTH{1'b0}};
            iDone_q     <= 1'b0;
            iRdData_q   <= {`DATA_WIDTH{1'b0}};
        end else begin
            dDone_q <= 1'b0;
            iDone_q <= 1'b0;
            case (state_q)
                IDLE: begin
                    if (takeD) begin
                        port_q     <= `PORT_D;
                        write_q    <= dWrite;
                        addr_q     <= dAddr;
                        wdata_q    <= dWrData;
                        // io never cached; disabled cache bypassed entirely
                        useCache_q <= dcOn && !dIo;
                        state_q    <= (dcOn && !dIo) ? LOOKUP : LOWER;
                        lowReq_q   <= !(dcOn && !dIo);
                        lowWrite_q <= dWrite;
                        lowAddr_q  <= dAddr;
                        lowWrData_q <= dWrData;
                    end else if (takeI) begin
                        port_q     <= `PORT_I;
                        write_q    <= 1'b0;
                        addr_q     <= iAddr;
                        useCache_q <= icOn;
                        state_q    <= icOn ? LOOKUP : LOWER;
                        lowReq_q   <= !icOn;
                        lowWrite_q <= 1'b0;
                        lowAddr_q  <= iAddr;
                    end
                end
                LOOKUP: begin
                    if (!write_q && hit) begin
                        state_q <= IDLE;
                        if (port_q == `PORT_D) begin
                            dDone_q   <= 1'b1;
                            dRdData_q <= dData;
                        end else begin
                            iDone_q   <= 1'b1;
                            iRdData_q <= iData;
                        end
                    end else begin
                        // stores write through so lower levels stay current
                        state_q  <= LOWER;
                        lowReq_q <= 1'b1;
                    end
                end
                LOWER: begin
                    if (lowAck) begin
                        state_q  <= IDLE;
                        lowReq_q <= 1'b0;
                        if (port_q == `PORT_D) begin
                            dDone_q   <= 1'b1;
                            dRdData_q <= write_q ? wdata_q : lowRdData;
                        end else begin
                            iDone_q   <= 1'b1;
                            iRdData_q <= lowRdData;
                        end
                    end
                end
                default: begin
                    state_q  <= IDLE;
                    lowReq_q <= 1'b0;
                end
            endcase
        end
    end

endmodule

// File: sim/l1_cache_enable_control_props.sv
`timescale 1ns/1ps
`include "l1_cache_defines.vh"
module l1_cache_enable_control_props #(
    parameter DC_BUILT = 1,
    parameter IC_BUILT = 1
) (
    // clock, reset, control
    input wire                   clock,
    input wire                   rst_n,
    input wire                   ctlWrite,
    input wire [`CTL_WIDTH-1:0]  ctlWrData,
    input wire [`CTL_WIDTH-1:0]  ctlRdData,
    // core side
    input wire                   dReq,
    input wire                   dWrite,
    input wire                   dIo,
    input wire [`ADDR_WIDTH-1:0] dAddr,
    input wire                   dReady,
    input wire                   dDone_q,
    input wire [`DATA_WIDTH-1:0] dRdData_q,
    input wire                   iReq,
    input wire [`ADDR_WIDTH-1:0] iAddr,
    input wire                   iReady,
    input wire                   iDone_q,
    input wire [`DATA_WIDTH-1:0] iRdData_q,
    // lower level
    input wire                   lowReq_q,
    input wire                   lowWrite_q,
    input wire [`ADDR_WIDTH-1:0] lowAddr_q,
    input wire [`DATA_WIDTH-1:0] lowWrData_q,
    input wire                   lowAck,
    input wire [`DATA_WIDTH-1:0] lowRdData
);
    wire [1:0] built = {DC_BUILT != 0, IC_BUILT != 0};
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);
    property p_ctl_load; ctlWrite |=> ctlRdData == ($past(ctlWrData) & built); endproperty
    property p_unbuilt; (ctlRdData & ~built) == 2'h0; endproperty
    property p_dc_off; dReq && dReady && !ctlRdData[`CTL_DC_BIT] |=> lowReq_q && lowAddr_q == $past(dAddr); endproperty
    property p_ic_off; iReq && iReady && !ctlRdData[`CTL_IC_BIT] |=> lowReq_q && !lowWrite_q && lowAddr_q == $past(iAddr);
    endproperty
    property p_io; dReq && dReady && dIo |=> lowReq_q; endproperty
    property p_store; dReq && dReady && dWrite |-> ##[1:2] lowReq_q && lowWrite_q; endproperty
    property p_low_hold; lowReq_q && !lowAck |=> lowReq_q && $stable(lowAddr_q) && $stable(lowWrData_q); endproperty
    property p_fill; lowReq_q && lowAck && !lowWrite_q |=> (dDone_q || iDone_q) && !lowReq_q &&
        (dDone_q ? dRdData_q : iRdData_q) == $past(lowRdData); endproperty
    a_ctl_load: assert property (p_ctl_load) else $error("enable register load wrong");
    a_unbuilt: assert property (p_unbuilt) else $error("absent enable bit reads one");
    a_dc_off: assert property (p_dc_off) else $error("data access not sent below");
    a_ic_off: assert property (p_ic_off) else $error("fetch not sent below");
    a_io: assert property (p_io) else $error("io access cached");
    a_store: assert property (p_store) else $error("store not written through");
    a_low_hold: assert property (p_low_hold) else $error("lower request changed early");
    a_fill: assert property (p_fill) else $error("lower data not returned");
    c_dhit: cover property (dReq && dReady ##2 dDone_q && !lowReq_q);
    c_idone: cover property (iDone_q);
    c_wr: cover property (lowReq_q && lowAck && lowWrite_q);
endmodule
bind l1_cache_enable_control l1_cache_enable_control_props #(.DC_BUILT(DC_BUILT), .IC_BUILT(IC_BUILT)) props (
    .clock, .rst_n, .ctlWrite, .ctlWrData, .ctlRdData, .dReq, .dWrite, .dIo, .dAddr, .dReady, .dDone_q, .dRdData_q,
    .iReq, .iAddr, .iReady, .iDone_q, .iRdData_q, .lowReq_q, .lowWrite_q, .lowAddr_q, .lowWrData_q, .lowAck,
    .lowRdData);

// File: sim/lower_level_model.sv
`timescale 1ns/1ps
module lower_level_model (
    // clock and reset
    input wire         clock,
    input wire         rst_n,
    // request from the cache
    input wire         lowReq_q,
    input wire         lowWrite_q,
    input wire  [31:0] lowAddr_q,
    input wire  [31:0] lowWrData_q,
    input wire  [3:0]  lat,
    // answer
    output logic        lowAck,
    output logic [31:0] lowRdData
);
    // word store over a 4 KB window, enough for the addresses the scenarios use
    logic [31:0]   mem [0:1023];
    logic [1023:0] written;
    logic [3:0]    waitCnt;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            lowAck <= 1'b0;
            lowRdData <= 32'h0;
            waitCnt <= 4'h0;
            written <= {1024{1'b0}};
        end else begin
            lowAck <= 1'b0;
            // data toggles outside an answer, so a late sample shows
            lowRdData <= ~lowRdData;
            if (lowReq_q && !lowAck) begin
                waitCnt <= waitCnt + 4'h1;
                if (waitCnt == lat) begin
                    waitCnt <= 4'h0;
                    lowAck <= 1'b1;
                    if (lowWrite_q) begin
                        mem[lowAddr_q[11:2]]     <= lowWrData_q;
                        written[lowAddr_q[11:2]] <= 1'b1;
                    end
                    lowRdData <= written[lowAddr_q[11:2]] ? mem[lowAddr_q[11:2]] : lowAddr_q ^ 32'h5a5a_5a5a;
                end
            end
        end
    end
endmodule

// File: sim/l1_cache_enable_control_test.sv
`timescale 1ns/1ps
module l1_cache_enable_control_test;
    logic        clock = 1'b0, rst_n = 1'b0, ctlWrite = 1'b0, dReq = 1'b0, dWrite = 1'b0, dIo = 1'b0, iReq = 1'b0;
    logic        dFlushLine = 1'b0, iInvalidateAll = 1'b0, snoopValid = 1'b0;
    logic [1:0]  ctlWrData = 2'h0, ctlRdData, bareRdData;
    logic [3:0]  maintIndex = 4'h0, lat = 4'h0;
    logic [31:0] dAddr = 32'h0, dWrData = 32'h0, iAddr = 32'h0, snoopAddr = 32'h0;
    logic [31:0] dRdData_q, iRdData_q, lowAddr_q, lowWrData_q, lowRdData, rd;
    logic        dReady, dDone_q, iReady, iDone_q, lowReq_q, lowWrite_q, lowAck;
    int          failCount = 0, checksDone = 0, cycles = 0, lowCount = 0, n;
    always #25 clock = ~clock;
    l1_cache_enable_control dut (.clock, .rst_n, .ctlWrite, .ctlWrData, .ctlRdData, .dReq, .dWrite, .dIo, .dAddr,
        .dWrData, .dReady, .dDone_q, .dRdData_q, .iReq, .iAddr, .iReady, .iDone_q, .iRdData_q, .dFlushLine,
        .iInvalidateAll, .maintIndex, .snoopValid, .snoopAddr, .lowReq_q, .lowWrite_q, .lowAddr_q, .lowWrData_q,
        .lowAck, .lowRdData);
    lower_level_model partner (.clock, .rst_n, .lowReq_q, .lowWrite_q, .lowAddr_q, .lowWrData_q, .lat, .lowAck,
        .lowRdData);
    // data cache enable left unbuilt: that bit must read zero whatever is written
    l1_cache_enable_control #(.DC_BUILT(0), .IC_BUILT(1)) dutNoDc (.clock, .rst_n, .ctlWrite, .ctlWrData,
        .ctlRdData(bareRdData), .dReq(1'b0), .dWrite(1'b0), .dIo(1'b0), .dAddr(32'h0), .dWrData(32'h0),
        .dReady(), .dDone_q(), .dRdData_q(), .iReq(1'b0), .iAddr(32'h0), .iReady(), .iDone_q(), .iRdData_q(),
        .dFlushLine(1'b0), .iInvalidateAll(1'b0), .maintIndex(4'h0), .snoopValid(1'b0), .snoopAddr(32'h0),
        .lowReq_q(), .lowWrite_q(), .lowAddr_q(), .lowWrData_q(), .lowAck(1'b0), .lowRdData(32'h0));
    always @(posedge clock) begin
        cycles++;
        if (lowReq_q && lowAck)
            lowCount++;
        if (cycles == 4000) begin
            failCount++;
            tallyAndFinish();
        end
    end
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] mval(input logic [31:0] a);
        return a ^ 32'h5a5a_5a5a;
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checksDone++;
        if (got !== exp) begin
            failCount++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic ctlSet(input logic [1:0] v);
        @(posedge clock);
        ctlWrite <= 1'b1;
        ctlWrData <= v;
        @(posedge clock);
        ctlWrite <= 1'b0;
    endtask
    task automatic pulse(input int which, input logic [31:0] a);
        @(posedge clock);
        {iInvalidateAll, dFlushLine, snoopValid} <= 3'h1 << which;
        maintIndex <= a[7:4];
        snoopAddr <= a;
        @(posedge clock);
        {iInvalidateAll, dFlushLine, snoopValid} <= 3'h0;
    endtask
    // one request outstanding, so ready is high when a task starts
    task automatic access(input logic fetch, wr, io, input logic [31:0] a, wd);
        @(posedge clock);
        {iReq, dReq} <= fetch ? 2'h2 : 2'h1;
        {dWrite, dIo, dAddr, iAddr, dWrData} <= {wr, io, a, a, wd};
        @(posedge clock);
        {iReq, dReq} <= 2'h0;
        repeat (40) begin
            @(negedge clock);
            if (dDone_q || iDone_q)
                break;
        end
        chk("done", 32'h1, {31'h0, fetch ? iDone_q : dDone_q});
        rd = fetch ? iRdData_q : dRdData_q;
    endtask
    task automatic load(input logic fetch, input logic [31:0] a, exp, input int lows);
        n = lowCount;
        access(fetch, 1'b0, 1'b0, a, 32'h0);
        chk("read data", exp, rd);
        chk("lower accesses", lows, lowCount - n);
    endtask
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_reset_and_ctl;
        chk("ctl after reset", 32'h0, {30'h0, ctlRdData});
        chk("ready after reset", 32'h3, {30'h0, dReady, iReady});
        for (int v = 0; v < 4; v++) begin
            ctlSet(v[1:0]);
            @(negedge clock);
            chk("ctl readback", v, {30'h0, ctlRdData});
            chk("ctl readback no dc", v & 1, {30'h0, bareRdData});
        end
    endtask
    task automatic t_data_cache;
        ctlSet(2'h0);
        load(0, 32'h100, mval(32'h100), 1);
        load(0, 32'h100, mval(32'h100), 1);
        lat <= 4'h3;
        ctlSet(2'h2);
        load(0, 32'h210, mval(32'h210), 1);
        load(0, 32'h210, mval(32'h210), 0);
        load(0, 32'h100, mval(32'h100), 1);
        load(0, 32'h210, mval(32'h210), 0);
        ctlSet(2'h0);
        access(0, 1'b1, 1'b0, 32'h210, 32'h1234_abcd);
        chk("store echo", 32'h1234_abcd, rd);
        ctlSet(2'h2);
        load(0, 32'h210, mval(32'h210), 0);
        pulse(1, 32'h210);
        load(0, 32'h210, 32'h1234_abcd, 1);
        access(0, 1'b1, 1'b0, 32'h210, 32'h0f0f_7777);
        load(0, 32'h210, 32'h0f0f_7777, 0);
        lat <= 4'h0;
    endtask
    task automatic t_io_and_snoop;
        for (int k = 0; k < 2; k++) begin
            n = lowCount;
            access(0, 1'b0, 1'b1, 32'h320, 32'h0);
            chk("io data", mval(32'h320), rd);
            chk("io lower accesses", 1, lowCount - n);
        end
        load(0, 32'h430, mval(32'h430), 1);
        pulse(0, 32'h430);
        load(0, 32'h430, mval(32'h430), 1);
    endtask
    task automatic t_instr_cache;
        ctlSet(2'h1);
        load(1, 32'h540, mval(32'h540), 1);
        load(1, 32'h540, mval(32'h540), 0);
        ctlSet(2'h0);
        load(1, 32'h540, mval(32'h540), 1);
        ctlSet(2'h1);
        pulse(2, 32'h0);
        load(1, 32'h540, mval(32'h540), 1);
    endtask
    task automatic tallyAndFinish;
        if (failCount == 0 && checksDone > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge clock);
        rst_n <= 1'b1;
        t_reset_and_ctl();
        t_data_cache();
        t_io_and_snoop();
        t_instr_cache();
        tallyAndFinish();
    end
endmodule
